// *** inc/bmsvc_pkg.sv ***
// Constants and types shared by the bridge mode select and vendor command decode block
package bmsvc_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned EN_SAMPLE_NS = 16_666_666;
    localparam int unsigned EN_SAMPLE_CYC = EN_SAMPLE_NS / CLK_PERIOD_NS;
    localparam int unsigned RST_HOLD_NS = 10_000_000;
    localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned EN_CNT_W = 22;

    // Register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DESIG = 8'h08;
    localparam logic [7:0] REG_LEN = 8'h0c;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int unsigned CTRL_LEN_CHK_BIT = 0;

    // Configuration memory layout
    localparam logic [7:0] CFG_SIG_VALUE = 8'h4d;
    localparam logic [7:0] CFG_ADDR_SIG0 = 8'h00;
    localparam logic [7:0] CFG_ADDR_SIG1 = 8'h01;
    localparam logic [7:0] CFG_ADDR_DESIG = 8'h04;
    localparam logic [7:0] DESIG_DEFAULT = 8'h24;

    // Command wrapper layout
    localparam logic [4:0] CBW_LEN_FIRST = 5'h08;
    localparam logic [4:0] CBW_LEN_LAST = 5'h0b;
    localparam logic [4:0] CBW_FLAGS = 5'h0c;
    localparam int unsigned CBW_DIR_BIT = 7;
    localparam logic [4:0] CBW_CB0 = 5'h0f;
    localparam logic [4:0] CBW_CB1 = 5'h10;
    localparam logic [4:0] CBW_CB2 = 5'h11;
    localparam logic [4:0] CBW_CB3 = 5'h12;
    localparam logic [4:0] CBW_CB5 = 5'h14;
    localparam logic [4:0] CBW_LAST = 5'h1e;

    // Vendor command codes and limits
    localparam logic [7:0] SUB_CFG = 8'h26;
    localparam logic [7:0] SUB_MFG = 8'h27;
    localparam logic [7:0] CFG_SRC_MEM = 8'h02;
    localparam logic [31:0] CFG_MAX_LEN = 32'h0000_00ff;
    localparam logic [31:0] MFG_LOAD_LEN = 32'h0000_0007;
    localparam logic [31:0] MFG_READ_LEN = 32'h0000_0008;
    localparam logic [2:0] MFG_LOAD_LAST = 3'h6;
    localparam int unsigned MFG_DD_EN_BIT = 15;

    // USB speed capability: bit 1 high speed, bit 0 full speed
    localparam logic [1:0] USB_SPEED_CAP = 2'h3;

    typedef enum logic [2:0] {
        ST_RD_SIG0 = 3'b000,
        ST_RD_SIG1 = 3'b001,
        ST_RD_DESIG = 3'b010,
        ST_NORMAL = 3'b011,
        ST_TEST = 3'b100,
        ST_OFF = 3'b101
    } bmsvc_state_e;

endpackage

// *** inc/bmsvc_cmd_if.sv ***
// Decoded command wrapper fields passed from the decoder to the mode controller
`timescale 1ns/10ps
interface bmsvc_cmd_if;
    logic valid;
    logic [7:0] cb0;
    logic [7:0] sub;
    logic cfg_ok;
    logic mfg_ok;
    logic [31:0] len;
    logic dir_in;

    modport producer (output valid, output cb0, output sub, output cfg_ok, output mfg_ok,
        output len, output dir_in);
    modport consumer (input valid, input cb0, input sub, input cfg_ok, input mfg_ok,
        input len, input dir_in);
endinterface

// *** hw/bmsvc_en_sampler.sv ***
// Storage port enable synchroniser and slow periodic sampler with edge detect
`timescale 1ns/10ps
module bmsvc_en_sampler
    import bmsvc_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC = bmsvc_pkg::EN_SAMPLE_CYC
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic sync1;
    logic sync2;
    logic [EN_CNT_W-1:0] cnt;
    logic [EN_CNT_W-1:0] next_cnt;
    logic next_level;
    logic next_rise;
    logic next_fall;
    logic tick;

    // Level only moves at sample points, so glitches between them are invisible
    always_comb begin
        tick = (cnt == EN_CNT_W'(SAMPLE_CYC - 1));
        next_cnt = tick ? '0 : cnt + 1'b1;
        next_level = level_o;
        next_rise = 1'b0;
        next_fall = 1'b0;
        if (tick) begin
            next_level = sync2;
            next_rise = sync2 & ~level_o;
            next_fall = ~sync2 & level_o;
        end
    end

    // Start-up assumes the pin high so no false rise fires after reset
    always_ff @(posedge sys_clk_i) begin
        sync1 <= pin_i;
        sync2 <= sync1;
        if (sys_rst_i) begin
            cnt <= '0;
            level_o <= 1'b1;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            level_o <= next_level;
            rise_o <= next_rise;
            fall_o <= next_fall;
        end
    end

    property p_edge_at_sample;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (rise_o || fall_o) |-> $past(tick) && (cnt == '0);
    endproperty
    a_edge_at_sample: assert property (p_edge_at_sample)
        else $error("enable edge seen away from a sample point");

endmodule // bmsvc_en_sampler

// *** hw/bmsvc_cbw_decoder.sv ***
// Command wrapper byte stream parser: length, direction and vendor block fields
`timescale 1ns/10ps
module bmsvc_cbw_decoder
    import bmsvc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic cbw_valid_i,
    input wire logic cbw_first_i,
    input wire logic [7:0] cbw_byte_i,
    bmsvc_cmd_if.producer cmd
);
    logic [4:0] idx;
    logic [4:0] next_idx;
    logic [4:0] cur;
    logic [31:0] next_len;
    logic next_dir;
    logic [7:0] next_cb0;
    logic [7:0] next_sub;
    logic next_cfg_ok;
    logic next_mfg_ok;
    logic next_valid;

    function automatic logic is_zero(input logic [7:0] b);
        is_zero = (b == 8'h00);
    endfunction

    // Fields land by byte position; reserved bytes fold into running checks
    always_comb begin
        cur = cbw_first_i ? 5'h00 : idx;
        next_idx = idx;
        next_len = cmd.len;
        next_dir = cmd.dir_in;
        next_cb0 = cmd.cb0;
        next_sub = cmd.sub;
        next_cfg_ok = cmd.cfg_ok;
        next_mfg_ok = cmd.mfg_ok;
        next_valid = 1'b0;
        if (cbw_valid_i) begin
            next_idx = (cur == CBW_LAST) ? 5'h00 : cur + 5'h01;
            if (cur == 5'h00) begin
                next_cfg_ok = 1'b1;
                next_mfg_ok = 1'b1;
            end
            if (cur >= CBW_LEN_FIRST && cur <= CBW_LEN_LAST) begin
                next_len[{cur[1:0], 3'b000} +: 8] = cbw_byte_i;
            end
            if (cur == CBW_FLAGS) begin
                next_dir = cbw_byte_i[CBW_DIR_BIT];
            end
            if (cur == CBW_CB0) begin
                next_cb0 = cbw_byte_i;
            end
            if (cur == CBW_CB1) begin
                next_sub = cbw_byte_i;
            end
            if (cur >= CBW_CB2) begin
                next_mfg_ok = cmd.mfg_ok & is_zero(cbw_byte_i);
                if (cur == CBW_CB3) begin
                    next_cfg_ok = cmd.cfg_ok & (cbw_byte_i == CFG_SRC_MEM);
                end else begin
                    next_cfg_ok = cmd.cfg_ok & is_zero(cbw_byte_i);
                end
            end
            next_valid = (cur == CBW_LAST);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            idx <= 5'h00;
            cmd.len <= 32'h0000_0000;
            cmd.dir_in <= 1'b0;
            cmd.cb0 <= 8'h00;
            cmd.sub <= 8'h00;
            cmd.cfg_ok <= 1'b0;
            cmd.mfg_ok <= 1'b0;
            cmd.valid <= 1'b0;
        end else begin
            idx <= next_idx;
            cmd.len <= next_len;
            cmd.dir_in <= next_dir;
            cmd.cb0 <= next_cb0;
            cmd.sub <= next_sub;
            cmd.cfg_ok <= next_cfg_ok;
            cmd.mfg_ok <= next_mfg_ok;
            cmd.valid <= next_valid;
        end
    end

endmodule // bmsvc_cbw_decoder

// *** hw/bmsvc_top.sv ***
// Bridge operating mode select, storage port enable handling and vendor command decode
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/10ps

// Summary of operation
// - Enable high runs the storage port; low floats it and disconnects USB. The code acts only on a fall seen in normal operation, not on a low level.
// - Enable pin is sampled sixty times a second; edges seen only then.
// - Detected fall floats storage port, disconnects USB, idles until reset or rise; the code ignores a fall outside normal operation.
// - Detected rise restarts from the post-reset state and reconnects USB.
// - Reset held ten milliseconds resets the whole block.
// - Only full and high speed USB are offered, never low speed.
// - Start-up reads config memory; valid only if bytes 0 and 1 are 0x4d.
// - Valid signature: descriptors from stored config, normal bridge operation.
// - Bad signature or no memory answer selects board test mode.
// - Test mode still enumerates but keeps the storage port inactive.
// - Test mode accepts config access and board test vendor commands.
// - Vendor command byte 0 must equal designator from config location 4; test mode uses the default 0x24, as location 4 is not read there.
// - Subcommand 0x26 in byte 1 marks config memory access.
// - Config memory transfer is limited to 255 bytes.
// - Data phase length comes from wrapper bytes 8 to 11.
// - Load or read variant comes from wrapper byte 12 bit 7.
// - Subcommand 0x27 with bytes 2 to 15 zero marks board test.
// - Board test load carries seven bytes setting test pin values and enables.
// - Board test read returns eight bytes of input pin snapshot.
// - Test mode is left only through a hard reset.
module bmsvc_top
    import bmsvc_pkg::*;
#(
    parameter int unsigned EN_SAMPLE_CYC_P = bmsvc_pkg::EN_SAMPLE_CYC
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic storage_port_enable_i,
    input wire logic bus_power_present_i,
    output logic cfg_req_o,
    output logic [7:0] cfg_addr_o,
    input wire logic cfg_ack_i,
    input wire logic cfg_nak_i,
    input wire logic [7:0] cfg_data_i,
    input wire logic cbw_valid_i,
    input wire logic cbw_first_i,
    input wire logic [7:0] cbw_byte_i,
    input wire logic dat_valid_i,
    input wire logic [7:0] dat_byte_i,
    input wire logic ata_intrq_i,
    input wire logic ata_iordy_i,
    input wire logic ata_dmarq_i,
    input wire logic [15:0] ata_dd_i,
    output logic ata_oe_n_o,
    output logic usb_connect_o,
    output logic [1:0] usb_speed_cap_o,
    output logic test_mode_o,
    output logic desc_from_cfg_o,
    output logic cmd_done_o,
    output logic cmd_fail_o,
    output logic cmd_cfg_o,
    output logic cmd_mfg_o,
    output logic cmd_dir_in_o,
    output logic [31:0] cmd_len_o,
    output logic [55:0] test_load_o,
    output logic test_dd_oe_n_o,
    output logic [63:0] test_snap_o
);
    bmsvc_cmd_if cmd ();

    bmsvc_state_e state;
    bmsvc_state_e next_state;
    logic wait_ack;
    logic next_wait_ack;
    logic [7:0] designator;
    logic [7:0] next_designator;
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic next_cfg_req;
    logic [7:0] next_cfg_addr;
    logic en_level;
    logic en_rise;
    logic en_fall;
    logic [19:0] pin_s1;
    logic [19:0] pin_s2;
    logic next_done;
    logic next_fail;
    logic next_cmd_cfg;
    logic next_cmd_mfg;
    logic next_dir_in;
    logic [31:0] next_len;
    logic ld_active;
    logic next_ld_active;
    logic [2:0] ld_cnt;
    logic [2:0] next_ld_cnt;
    logic [55:0] next_load;
    logic [63:0] next_snap;
    logic hit;
    logic is_cfg;
    logic is_mfg;
    logic len_ok;
    logic [31:0] next_rdata;

    bmsvc_en_sampler #(
        .SAMPLE_CYC(EN_SAMPLE_CYC_P)
    ) u_en_sampler (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(storage_port_enable_i),
        .level_o(en_level),
        .rise_o(en_rise),
        .fall_o(en_fall)
    );

    bmsvc_cbw_decoder u_cbw_decoder (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .cbw_valid_i(cbw_valid_i),
        .cbw_first_i(cbw_first_i),
        .cbw_byte_i(cbw_byte_i),
        .cmd(cmd.producer)
    );

    // Pin inputs for the snapshot pass two flops before use
    always_ff @(posedge sys_clk_i) begin
        pin_s1 <= {bus_power_present_i, ata_intrq_i, ata_iordy_i, ata_dmarq_i, ata_dd_i};
        pin_s2 <= pin_s1;
    end

    // Mode sequencing: signature check, enable handling, sticky test mode
    always_comb begin
        next_state = state;
        next_wait_ack = wait_ack;
        next_designator = designator;
        next_cfg_req = 1'b0;
        next_cfg_addr = cfg_addr_o;
        unique case (state)
            ST_RD_SIG0, ST_RD_SIG1, ST_RD_DESIG: begin
                if (!wait_ack) begin
                    next_cfg_req = 1'b1;
                    next_wait_ack = 1'b1;
                    next_cfg_addr = (state == ST_RD_SIG0) ? CFG_ADDR_SIG0 :
                        (state == ST_RD_SIG1) ? CFG_ADDR_SIG1 : CFG_ADDR_DESIG;
                end else if (cfg_nak_i) begin
                    next_wait_ack = 1'b0;
                    next_state = ST_TEST;
                end else if (cfg_ack_i) begin
                    next_wait_ack = 1'b0;
                    if (state == ST_RD_DESIG) begin
                        next_designator = cfg_data_i;
                        next_state = ST_NORMAL;
                    end else if (cfg_data_i != CFG_SIG_VALUE) begin
                        next_state = ST_TEST;
                    end else begin
                        next_state = (state == ST_RD_SIG0) ? ST_RD_SIG1 : ST_RD_DESIG;
                    end
                end
            end
            ST_NORMAL: begin
                if (en_fall) begin
                    next_state = ST_OFF;
                end
            end
            ST_OFF: begin
                if (en_rise) begin
                    next_state = ST_RD_SIG0;
                    next_designator = DESIG_DEFAULT;
                end
            end
            ST_TEST: begin
                next_state = ST_TEST;
            end
            default: begin
                next_state = ST_TEST;
            end
        endcase
    end

    // Vendor commands are only claimed in test mode; elsewhere they pass by
    always_comb begin
        hit = (cmd.cb0 == designator);
        is_cfg = hit && (cmd.sub == SUB_CFG) && cmd.cfg_ok;
        is_mfg = hit && (cmd.sub == SUB_MFG) && cmd.mfg_ok;
        len_ok = !ctrl[CTRL_LEN_CHK_BIT] ||
            (cmd.len == (cmd.dir_in ? MFG_READ_LEN : MFG_LOAD_LEN));
        next_done = 1'b0;
        next_fail = cmd_fail_o;
        next_cmd_cfg = cmd_cfg_o;
        next_cmd_mfg = cmd_mfg_o;
        next_dir_in = cmd_dir_in_o;
        next_len = cmd_len_o;
        next_ld_active = ld_active;
        next_ld_cnt = ld_cnt;
        next_load = test_load_o;
        next_snap = test_snap_o;
        if (state == ST_TEST && cmd.valid) begin
            next_done = 1'b1;
            next_cmd_cfg = is_cfg;
            next_cmd_mfg = is_mfg;
            next_dir_in = cmd.dir_in;
            next_fail = !(is_cfg || (is_mfg && len_ok));
            next_len = cmd.len;
            if (is_cfg && cmd.len > CFG_MAX_LEN) begin
                next_len = CFG_MAX_LEN;
            end
            if (is_mfg) begin
                next_len = cmd.dir_in ? MFG_READ_LEN : MFG_LOAD_LEN;
            end
            if (is_mfg && len_ok && cmd.dir_in) begin
                next_snap = {32'h0000_0000, pin_s2[15:0], ~ata_oe_n_o, 1'b0, en_level,
                    pin_s2[16], pin_s2[17], 3'b000, test_load_o[7], pin_s2[19],
                    5'b00000, pin_s2[18]};
            end
            next_ld_active = is_mfg && len_ok && !cmd.dir_in;
            next_ld_cnt = 3'h0;
        end else if (ld_active && dat_valid_i) begin
            next_load[{ld_cnt, 3'b000} +: 8] = dat_byte_i;
            next_ld_cnt = ld_cnt + 3'h1;
            next_ld_active = (ld_cnt != MFG_LOAD_LAST);
        end
    end

    // Register bus: control write, status and command readback
    always_comb begin
        next_ctrl = ctrl;
        if (reg_wr_i && reg_addr_i == REG_CTRL) begin
            next_ctrl = {31'h0000_0000, reg_wdata_i[CTRL_LEN_CHK_BIT]};
        end
        next_rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_CTRL: next_rdata = ctrl;
                REG_STATUS: next_rdata = {24'h00_0000, ld_active, cmd_fail_o, en_level,
                    desc_from_cfg_o, test_mode_o, 3'(state)};
                REG_DESIG: next_rdata = {24'h00_0000, designator};
                REG_LEN: next_rdata = cmd_len_o;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // All registered state but the pin synchronisers; synchronous reset returns every mode to power-up
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state <= ST_RD_SIG0;
            wait_ack <= 1'b0;
            designator <= DESIG_DEFAULT;
            ctrl <= CTRL_RESET;
            cfg_req_o <= 1'b0;
            cfg_addr_o <= CFG_ADDR_SIG0;
            reg_rdata_o <= 32'h0000_0000;
            ata_oe_n_o <= 1'b1;
            usb_connect_o <= 1'b0;
            usb_speed_cap_o <= USB_SPEED_CAP;
            test_mode_o <= 1'b0;
            desc_from_cfg_o <= 1'b0;
            cmd_done_o <= 1'b0;
            cmd_fail_o <= 1'b0;
            cmd_cfg_o <= 1'b0;
            cmd_mfg_o <= 1'b0;
            cmd_dir_in_o <= 1'b0;
            cmd_len_o <= 32'h0000_0000;
            ld_active <= 1'b0;
            ld_cnt <= 3'h0;
            test_load_o <= 56'h00_0000_0000_0000;
            test_dd_oe_n_o <= 1'b1;
            test_snap_o <= 64'h0000_0000_0000_0000;
        end else begin
            state <= next_state;
            wait_ack <= next_wait_ack;
            designator <= next_designator;
            ctrl <= next_ctrl;
            cfg_req_o <= next_cfg_req;
            cfg_addr_o <= next_cfg_addr;
            reg_rdata_o <= next_rdata;
            ata_oe_n_o <= (state != ST_NORMAL);
            usb_connect_o <= (state == ST_NORMAL) || (state == ST_TEST);
            usb_speed_cap_o <= USB_SPEED_CAP;
            test_mode_o <= (state == ST_TEST);
            desc_from_cfg_o <= (state == ST_NORMAL);
            cmd_done_o <= next_done;
            cmd_fail_o <= next_fail;
            cmd_cfg_o <= next_cmd_cfg;
            cmd_mfg_o <= next_cmd_mfg;
            cmd_dir_in_o <= next_dir_in;
            cmd_len_o <= next_len;
            ld_active <= next_ld_active;
            ld_cnt <= next_ld_cnt;
            test_load_o <= next_load;
            test_dd_oe_n_o <= !((state == ST_TEST) && test_load_o[MFG_DD_EN_BIT]);
            test_snap_o <= next_snap;
        end
    end

    default clocking cb_main @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_fall_off;
        (state == ST_NORMAL) && en_fall |-> ##2 ata_oe_n_o && !usb_connect_o;
    endproperty
    a_fall_off: assert property (p_fall_off)
        else $error("storage port still driven after enable fall");

    property p_rise_restart;
        (state == ST_OFF) && en_rise |=> (state == ST_RD_SIG0) && (designator == DESIG_DEFAULT);
    endproperty
    a_rise_restart: assert property (p_rise_restart)
        else $error("enable rise did not restart start-up");

    property p_bad_sig;
        (state inside {ST_RD_SIG0, ST_RD_SIG1}) && wait_ack && !cfg_nak_i && cfg_ack_i &&
            (cfg_data_i != CFG_SIG_VALUE) |=> (state == ST_TEST) ##1 test_mode_o;
    endproperty
    a_bad_sig: assert property (p_bad_sig)
        else $error("bad signature did not select test mode");

    property p_test_sticky;
        (state == ST_TEST) |=> (state == ST_TEST) [*8];
    endproperty
    a_test_sticky: assert property (p_test_sticky)
        else $error("test mode was left without reset");

    property p_test_port_off;
        test_mode_o |-> ata_oe_n_o && usb_connect_o;
    endproperty
    a_test_port_off: assert property (p_test_port_off)
        else $error("storage port active or USB gone in test mode");

    property p_cfg_limit;
        cmd_done_o && cmd_cfg_o |-> (cmd_len_o <= CFG_MAX_LEN) && (cmd_len_o <= $past(cmd.len));
    endproperty
    a_cfg_limit: assert property (p_cfg_limit)
        else $error("config transfer exceeds limit");

    property p_mfg_read_len;
        cmd_done_o && cmd_mfg_o && !cmd_fail_o && cmd_dir_in_o |-> (cmd_len_o == MFG_READ_LEN);
    endproperty
    a_mfg_read_len: assert property (p_mfg_read_len)
        else $error("board test read length is not eight");

    property p_bad_cmd_fails;
        (state == ST_TEST) && cmd.valid && (cmd.cb0 != designator) |=> cmd_done_o && cmd_fail_o;
    endproperty
    a_bad_cmd_fails: assert property (p_bad_cmd_fails)
        else $error("foreign designator not reported as failure");

    property p_sig_ok_normal;
        (state == ST_RD_DESIG) && wait_ack && !cfg_nak_i && cfg_ack_i
            |=> (state == ST_NORMAL) ##1 desc_from_cfg_o && !ata_oe_n_o;
    endproperty
    a_sig_ok_normal: assert property (p_sig_ok_normal)
        else $error("valid signature did not reach normal operation");

    property p_no_low_speed;
        usb_speed_cap_o == USB_SPEED_CAP;
    endproperty
    a_no_low_speed: assert property (p_no_low_speed)
        else $error("speed capability changed");

    c_normal: cover property ((state == ST_RD_DESIG) ##1 (state == ST_NORMAL));
    c_off_and_back: cover property ((state == ST_OFF) ##1 (state == ST_RD_SIG0));
    c_cfg_cmd: cover property (cmd_done_o && cmd_cfg_o && !cmd_fail_o);
    c_mfg_load: cover property (ld_active && dat_valid_i && (ld_cnt == MFG_LOAD_LAST));

endmodule // bmsvc_top

// *** tb/bmsvc_cfg_mem_model.sv ***
// Configuration memory model answering byte read requests
`timescale 1ns/10ps
module bmsvc_cfg_mem_model (
    input wire logic sys_clk_i,
    input wire logic good_i,
    input wire logic req_i,
    input wire logic [7:0] addr_i,
    output logic ack_o,
    output logic [7:0] data_o
);
    // Slow answer, two cycles late; data lines scrambled once released
    initial begin
        ack_o = 1'b0;
        data_o = 8'h5a;
        forever begin
            @(posedge sys_clk_i);
            #1;
            if (req_i) begin
                repeat (2) @(posedge sys_clk_i);
                ack_o <= 1'b1;
                data_o <= (addr_i == 8'h04) ? 8'h24 : (good_i ? 8'h4d : 8'h00);
                @(posedge sys_clk_i);
                ack_o <= 1'b0;
                data_o <= ~data_o;
            end
        end
    end
endmodule // bmsvc_cfg_mem_model

// *** tb/tb_bmsvc_top.sv ***
// Self-checking bench for the mode select and vendor command decode block
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_bmsvc_top;
    logic sys_clk_i = 0, sys_rst_i = 1, wr = 0, rd = 0, en = 1, cv = 0, cf = 0, dv = 0, good = 0;
    logic [7:0] ad = 0, cb = 0, db = 0;
    logic [31:0] wd = 0, rdat, rv;
    logic [15:0] dd = 16'hc3a5;
    logic irq = 1, ddoe_n;
    logic [63:0] snap;
    logic req, ack, oe_n, con, tm, dfc, done, fail, ccfg, cmfg, dirin;
    logic [7:0] caddr, cdat;
    logic [1:0] spd;
    logic [31:0] len;
    logic [55:0] tload;
    int fail_count = 0, samples_checked = 0;
    bmsvc_cfg_mem_model mem (.sys_clk_i(sys_clk_i), .good_i(good), .req_i(req), .addr_i(caddr),
        .ack_o(ack), .data_o(cdat));
    bmsvc_top #(.EN_SAMPLE_CYC_P(16)) dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
        .storage_port_enable_i(en), .bus_power_present_i(1'b1), .cfg_req_o(req),
        .cfg_addr_o(caddr), .cfg_ack_i(ack), .cfg_nak_i(1'b0), .cfg_data_i(cdat),
        .cbw_valid_i(cv), .cbw_first_i(cf), .cbw_byte_i(cb), .dat_valid_i(dv), .dat_byte_i(db),
        .ata_intrq_i(irq), .ata_iordy_i(1'b1), .ata_dmarq_i(1'b0), .ata_dd_i(dd),
        .ata_oe_n_o(oe_n), .usb_connect_o(con), .usb_speed_cap_o(spd), .test_mode_o(tm),
        .desc_from_cfg_o(dfc), .cmd_done_o(done), .cmd_fail_o(fail), .cmd_cfg_o(ccfg),
        .cmd_mfg_o(cmfg), .cmd_dir_in_o(dirin), .cmd_len_o(len), .test_load_o(tload),
        .test_dd_oe_n_o(ddoe_n), .test_snap_o(snap));
    // Clock, 8 ns period
    initial forever #4 sys_clk_i = ~sys_clk_i;
    task automatic test_done();
        if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic boot(input logic g);
        good <= g;
        sys_rst_i <= 1'b1;
        repeat (16) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        repeat (30) @(posedge sys_clk_i);
    endtask
    // One register access; read data sampled in the following cycle only
    task automatic reg_acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        wr <= w;
        rd <= ~w;
        ad <= a;
        wd <= d;
        @(posedge sys_clk_i);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 rv = rdat;
        @(posedge sys_clk_i);
    endtask
    // Whole wrapper of 31 bytes, then a bounded wait for the decode pulse
    task automatic send(input logic [7:0] c0, s, input logic [31:0] l, input logic d);
        for (int i = 0; i < 31; i++) begin
            cv <= 1'b1;
            cf <= (i == 0);
            cb <= (i >= 8 && i <= 11) ? l[8*(i-8) +: 8] : (i == 12) ? {d, 7'h00} :
                (i == 15) ? c0 : (i == 16) ? s : (i == 18 && s == 8'h26) ? 8'h02 : 8'h00;
            @(posedge sys_clk_i);
        end
        cv <= 1'b0;
        for (int k = 0; k < 8 && done !== 1'b1; k++) @(posedge sys_clk_i);
        `CHK("done", 1'b1, done)
    endtask
    initial begin
        #40_000;
        fail_count++;
        test_done();
    end
    initial begin
        boot(1'b0);
        `CHK("tm", 3'b111, {tm, con, oe_n})
        `CHK("spd", 2'h3, spd)
        reg_acc(1'b0, 8'h04, 0);
        `CHK("status", 8'h2c, rv[7:0])
        reg_acc(1'b0, 8'h40, 0);
        `CHK("unmapped", 32'h0, rv)
        send(8'h25, 8'h26, 32'd8, 1'b0);
        `CHK("foreign", 1'b1, fail)
        send(8'h24, 8'h26, 32'd300, 1'b1);
        `CHK("cfg", 5'b01010, {fail, ccfg, cmfg, dirin, 1'b0})
        `CHK("len", 32'd255, len)
        send(8'h24, 8'h27, 32'd8, 1'b1);
        `CHK("mfgrd", 4'b0011, {fail, ccfg, cmfg, dirin})
        `CHK("snap", 64'h0000_0000_c3a5_2841, snap)
        send(8'h24, 8'h28, 32'd8, 1'b1);
        `CHK("badsub", 1'b1, fail)
        send(8'h24, 8'h27, 32'd7, 1'b0);
        `CHK("mfgld", 4'b0010, {fail, ccfg, cmfg, dirin})
        for (int i = 0; i < 7; i++) begin
            dv <= 1'b1;
            db <= 8'h90 + i[7:0];
            @(posedge sys_clk_i);
        end
        dv <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        `CHK("load", 56'h96959493929190, tload)
        `CHK("ddoe", 1'b0, ddoe_n)
        reg_acc(1'b1, 8'h00, 0);
        reg_acc(1'b0, 8'h00, 0);
        `CHK("ctrl", 32'h0, rv)
        en <= 1'b0;
        repeat (60) @(posedge sys_clk_i);
        `CHK("tmstay", 2'b11, {tm, con})
        en <= 1'b1;
        boot(1'b1);
        `CHK("normal", 4'b0110, {tm, dfc, con, oe_n})
        en <= 1'b0;
        repeat (60) @(posedge sys_clk_i);
        `CHK("off", 2'b01, {con, oe_n})
        en <= 1'b1;
        repeat (100) @(posedge sys_clk_i);
        `CHK("back", 2'b10, {con, oe_n})
        test_done();
    end
endmodule // tb_bmsvc_top
